// [src/clock_gen_status.sv]
// Status, lock tracking and mode selection logic of the multi-mode clock generator.
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - Set sticky loss-of-lock when locked loop drifts.
// - Loss-of-lock clears on reset or write one.
// - Interrupt requested only when enable bit set.
// - Lock bit follows active loop; off when disabled.
// - Reference divider, reference or loop select, trim (internal FLL modes), multiplier (PLL modes) changes clear lock.
// - Stop mode clears lock until relocked.
// - Low-power bypass clears lock until exited, relocked.
// - Loop status bit follows synchronised loop select.
// - Reference status follows synchronised reference select.
// - Clock mode status encodes source after synchronisation.
// - Bus clock is generator output divided by two.
// - FLL engaged output is reference times 1024.
// - PLL output uses multiplier; reference 1-2 MHz.
// - Bypass modes divide selected reference by bus divider.
// - Reset starts internal FLL engaged, reference divider zero, bus divider one.
// - Oscillator-initialised status bit set when crystal ready and external reference enabled.
// - Larger trim lengthens internal reference period.
//
// Our own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module clock_gen_status #(
	parameter int RELOCK_CYCLES = 16,
	parameter int MULT_STEP = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic [clock_gen_pkg::ADDR_W-1:0] addr,
	input wire logic [clock_gen_pkg::DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [clock_gen_pkg::DATA_W-1:0] rdata,
	input wire logic fll_lock_in,
	input wire logic pll_lock_in,
	input wire logic osc_ready_in,
	input wire logic stop_req,
	input wire logic gen_tick,
	output logic bus_clk,
	output logic lol_irq,
	output logic fll_enable,
	output logic pll_enable,
	output logic [7:0] ref_trim,
	output clock_gen_pkg::out_cfg_t out_cfg
);
	initial begin
		if (RELOCK_CYCLES < 1 || RELOCK_CYCLES > 255) $error("RELOCK_CYCLES out of range.");
		if (MULT_STEP < 1 || MULT_STEP * 15 > 2047) $error("MULT_STEP out of range.");
	end

	localparam logic [7:0] RELOCK_LOAD = 8'(RELOCK_CYCLES);
	localparam logic [6:0] MULT_STEP_W = 7'(MULT_STEP);

	//////////////////////////////////////////////////////////////////////////////
	// Register file.
	logic [7:0] ctrl1_q, ctrl1_d, ctrl2_q, ctrl2_d, trim_q, trim_d, ctrl3_q, ctrl3_d;
	logic [7:0] rdata_q, rdata_d;
	logic lol_flag_q, lol_flag_d;
	logic lock_q, lock_d;
	logic [7:0] status;
	logic disturb;
	clock_gen_pkg::gen_mode_t mode_q, mode_d;

	always_comb begin
		ctrl1_d = ctrl1_q;
		ctrl2_d = ctrl2_q;
		trim_d = trim_q;
		ctrl3_d = ctrl3_q;
		disturb = 1'b0;
		if (wr) begin
			case (addr)
				clock_gen_pkg::OFF_CTRL1: begin
					ctrl1_d = wdata;
					if (wdata[clock_gen_pkg::C1_REF_DIV_HI:clock_gen_pkg::C1_REF_SEL]
						!= ctrl1_q[clock_gen_pkg::C1_REF_DIV_HI:clock_gen_pkg::C1_REF_SEL])
						disturb = 1'b1;
				end
				clock_gen_pkg::OFF_CTRL2: ctrl2_d = wdata;
				clock_gen_pkg::OFF_TRIM: begin
					trim_d = wdata;
					if (wdata != trim_q && (mode_q == clock_gen_pkg::fll_engaged_internal_mode
						|| mode_q == clock_gen_pkg::fll_bypassed_internal_mode))
						disturb = 1'b1;
				end
				clock_gen_pkg::OFF_CTRL3: begin
					ctrl3_d = wdata;
					if (wdata[clock_gen_pkg::C3_LOOP_SEL] != ctrl3_q[clock_gen_pkg::C3_LOOP_SEL])
						disturb = 1'b1;
					if (wdata[clock_gen_pkg::C3_MULT_HI:0] != ctrl3_q[clock_gen_pkg::C3_MULT_HI:0]
						&& (mode_q == clock_gen_pkg::pll_engaged_external_mode
						|| mode_q == clock_gen_pkg::pll_bypassed_external_mode))
						disturb = 1'b1;
				end
				default: ;
			endcase
		end
		// Reads answer in the next cycle only; unmapped addresses answer zero.
		rdata_d = '0;
		if (rd) begin
			case (addr)
				clock_gen_pkg::OFF_CTRL1: rdata_d = ctrl1_q;
				clock_gen_pkg::OFF_CTRL2: rdata_d = ctrl2_q;
				clock_gen_pkg::OFF_TRIM: rdata_d = trim_q;
				clock_gen_pkg::OFF_STATUS: rdata_d = status;
				clock_gen_pkg::OFF_CTRL3: rdata_d = ctrl3_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			ctrl1_q <= clock_gen_pkg::CTRL1_RST;
			ctrl2_q <= clock_gen_pkg::CTRL2_RST;
			trim_q <= clock_gen_pkg::TRIM_RST;
			ctrl3_q <= clock_gen_pkg::CTRL3_RST;
			rdata_q <= '0;
		end else begin
			ctrl1_q <= ctrl1_d;
			ctrl2_q <= ctrl2_d;
			trim_q <= trim_d;
			ctrl3_q <= ctrl3_d;
			rdata_q <= rdata_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Selection crossing into the generator domain, modelled as two stages.
	clock_gen_pkg::sel_t sel_req, sync1_q, sync2_q;
	logic osc1_q, osc2_q;

	assign sel_req.loop_select = ctrl3_q[clock_gen_pkg::C3_LOOP_SEL];
	assign sel_req.reference_select = ctrl1_q[clock_gen_pkg::C1_REF_SEL];
	assign sel_req.clock_mode_select = ctrl1_q[clock_gen_pkg::C1_MODE_SEL_HI:clock_gen_pkg::C1_MODE_SEL_LO];

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			sync1_q <= '{1'b0, 1'b1, clock_gen_pkg::SRC_LOOP};
			sync2_q <= '{1'b0, 1'b1, clock_gen_pkg::SRC_LOOP};
			osc1_q <= 1'b0;
			osc2_q <= 1'b0;
		end else begin
			sync1_q <= sel_req;
			sync2_q <= sync1_q;
			osc1_q <= osc_ready_in;
			osc2_q <= osc1_q;
		end
	end

	//////////////////////////////////////////////////////////////////////////////
	// Mode decode from the selections actually in force.
	logic low_power;

	assign low_power = ctrl2_q[clock_gen_pkg::C2_LOW_POWER];

	always_comb begin
		case (sync2_q.clock_mode_select)
			clock_gen_pkg::SRC_LOOP: begin
				if (sync2_q.loop_select) mode_d = clock_gen_pkg::pll_engaged_external_mode;
				else if (sync2_q.reference_select) mode_d = clock_gen_pkg::fll_engaged_internal_mode;
				else mode_d = clock_gen_pkg::fll_engaged_external_mode;
			end
			clock_gen_pkg::SRC_INT: begin
				if (low_power) mode_d = clock_gen_pkg::low_power_internal_bypass;
				else mode_d = clock_gen_pkg::fll_bypassed_internal_mode;
			end
			clock_gen_pkg::SRC_EXT: begin
				if (low_power) mode_d = clock_gen_pkg::low_power_external_bypass;
				else if (sync2_q.loop_select) mode_d = clock_gen_pkg::pll_bypassed_external_mode;
				else mode_d = clock_gen_pkg::fll_bypassed_external_mode;
			end
			default: mode_d = mode_q;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) mode_q <= clock_gen_pkg::fll_engaged_internal_mode;
		else mode_q <= mode_d;
	end

	//////////////////////////////////////////////////////////////////////////////
	// Lock tracking. Lock-clearing writes, low-power entry and stop are kept apart from
	// real lock loss so that none of them raises the sticky flag before lock returns.
	logic [7:0] relock_q, relock_d;
	logic acq_q, acq_d;
	logic det_en, loop_locked, lost, lol_clr, enter_blp;
	logic fll_en_d, pll_en_d;
	clock_gen_pkg::out_cfg_t cfg_d;
	logic bus_clk_d;

	assign pll_en_d = (mode_d == clock_gen_pkg::pll_engaged_external_mode
		|| mode_d == clock_gen_pkg::pll_bypassed_external_mode);
	assign fll_en_d = (mode_d == clock_gen_pkg::fll_engaged_internal_mode
		|| mode_d == clock_gen_pkg::fll_engaged_external_mode
		|| mode_d == clock_gen_pkg::fll_bypassed_internal_mode
		|| mode_d == clock_gen_pkg::fll_bypassed_external_mode);
	assign det_en = fll_enable | pll_enable;
	assign loop_locked = sync2_q.loop_select ? pll_lock_in : fll_lock_in;
	assign enter_blp = (mode_d == clock_gen_pkg::low_power_internal_bypass
		|| mode_d == clock_gen_pkg::low_power_external_bypass) && mode_q != mode_d;
	assign lost = acq_q && det_en && !loop_locked && !disturb && relock_q == '0 && !stop_req;
	assign lol_clr = wr && addr == clock_gen_pkg::OFF_STATUS && wdata[clock_gen_pkg::ST_LOL_FLAG]
		&& lol_flag_q;

	always_comb begin
		relock_d = (relock_q != '0) ? relock_q - 8'h01 : relock_q;
		if (disturb || stop_req || enter_blp) relock_d = RELOCK_LOAD;
		lock_d = det_en && loop_locked && relock_q == '0 && !disturb && !stop_req && !enter_blp;
		acq_d = (acq_q | lock_q) && det_en && !disturb && !stop_req;
		lol_flag_d = (lol_flag_q && !lol_clr) || lost;
		bus_clk_d = gen_tick ? !bus_clk : bus_clk;
		cfg_d.src = sync2_q.clock_mode_select;
		if (sync2_q.clock_mode_select == clock_gen_pkg::SRC_LOOP && sync2_q.loop_select)
			cfg_d.src = clock_gen_pkg::SRC_PLL;
		cfg_d.bus_div_log2 = ctrl2_q[clock_gen_pkg::C2_BUS_DIV_HI:clock_gen_pkg::C2_BUS_DIV_LO];
		case (mode_d)
			clock_gen_pkg::fll_engaged_internal_mode: begin
				cfg_d.ref_div_log2 = '0;
				cfg_d.factor = clock_gen_pkg::FLL_FACTOR;
			end
			clock_gen_pkg::fll_engaged_external_mode: begin
				cfg_d.ref_div_log2 = ctrl1_q[clock_gen_pkg::C1_REF_DIV_HI:clock_gen_pkg::C1_REF_DIV_LO];
				cfg_d.factor = clock_gen_pkg::FLL_FACTOR;
			end
			clock_gen_pkg::pll_engaged_external_mode: begin
				cfg_d.ref_div_log2 = ctrl1_q[clock_gen_pkg::C1_REF_DIV_HI:clock_gen_pkg::C1_REF_DIV_LO];
				cfg_d.factor = 11'(ctrl3_q[clock_gen_pkg::C3_MULT_HI:0] * MULT_STEP_W);
			end
			default: begin
				cfg_d.ref_div_log2 = '0;
				cfg_d.factor = clock_gen_pkg::BYPASS_FACTOR;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			relock_q <= RELOCK_LOAD;
			lock_q <= 1'b0;
			acq_q <= 1'b0;
			lol_flag_q <= 1'b0;
			lol_irq <= 1'b0;
			fll_enable <= 1'b1;
			pll_enable <= 1'b0;
			bus_clk <= 1'b0;
			out_cfg <= '{clock_gen_pkg::SRC_LOOP, 3'h0, 2'h1, clock_gen_pkg::FLL_FACTOR};
		end else begin
			relock_q <= relock_d;
			lock_q <= lock_d;
			acq_q <= acq_d;
			lol_flag_q <= lol_flag_d;
			lol_irq <= lol_flag_d && ctrl3_q[clock_gen_pkg::C3_LOL_IRQ_EN];
			fll_enable <= fll_en_d;
			pll_enable <= pll_en_d;
			bus_clk <= bus_clk_d;
			out_cfg <= cfg_d;
		end
	end

	// Trim passes straight to the internal reference: a larger code gives a longer period.
	assign ref_trim = trim_q;
	assign rdata = rdata_q;

	// Status is composed from internal state only, so a write to it can only clear the loss-of-lock flag.
	always_comb begin
		status = '0;
		status[clock_gen_pkg::ST_LOL_FLAG] = lol_flag_q;
		status[clock_gen_pkg::ST_LOCK] = lock_q;
		status[clock_gen_pkg::ST_LOOP_STAT] = sync2_q.loop_select;
		status[clock_gen_pkg::ST_REF_STAT] = sync2_q.reference_select;
		status[clock_gen_pkg::ST_MODE_STAT_HI:clock_gen_pkg::ST_MODE_STAT_LO] = out_cfg.src;
		status[clock_gen_pkg::ST_OSC_INIT] = osc2_q && ctrl2_q[clock_gen_pkg::C2_EXT_REF_EN];
	end

	//////////////////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	lol_sticky_a: assert property (lol_flag_q && !lol_clr |=> lol_flag_q) else $error("Loss-of-lock flag dropped.");
	lol_clear_a: assert property (lol_clr && !lost |=> !lol_flag_q) else $error("Loss-of-lock clear failed.");
	irq_gate_a: assert property (##1 lol_irq == (lol_flag_q && $past(ctrl3_q[clock_gen_pkg::C3_LOL_IRQ_EN])))
		else $error("Interrupt not gated by enable.");
	lock_src_a: assert property (lock_q |-> $past(loop_locked)) else $error("Lock shown without loop lock.");
	blp_clear_a: assert property (enter_blp |=> !lock_q [*2]) else $error("Lock kept in low power.");
	lock_off_a: assert property (!det_en |=> !lock_q) else $error("Lock shown with detection off.");
	lock_clear_a: assert property (disturb |=> !lock_q [*2]) else $error("Lock kept after reconfiguration.");
	stop_clear_a: assert property (stop_req |=> !lock_q) else $error("Lock kept in stop.");
	sel_sync_a: assert property ($changed(sel_req.loop_select)
		|=> ##1 status[clock_gen_pkg::ST_LOOP_STAT] == $past(sel_req.loop_select, 2))
		else $error("Loop status not synchronised.");
	ref_sync_a: assert property (##2 status[clock_gen_pkg::ST_REF_STAT] == $past(sel_req.reference_select, 2))
		else $error("Reference status not two cycles late.");
	mode_stat_a: assert property (sync2_q.clock_mode_select == clock_gen_pkg::SRC_INT
		|=> status[clock_gen_pkg::ST_MODE_STAT_HI:clock_gen_pkg::ST_MODE_STAT_LO] == clock_gen_pkg::SRC_INT)
		else $error("Clock mode status wrong.");
	bus_div_a: assert property (gen_tick |=> bus_clk != $past(bus_clk)) else $error("Bus clock did not toggle.");
	fll_factor_a: assert property (mode_q == clock_gen_pkg::fll_engaged_external_mode
		|-> out_cfg.factor == clock_gen_pkg::FLL_FACTOR)
		else $error("FLL factor wrong.");
	pll_src_a: assert property (mode_q == clock_gen_pkg::pll_engaged_external_mode
		|-> out_cfg.src == clock_gen_pkg::SRC_PLL && pll_enable) else $error("PLL source wrong.");
	bypass_plan_a: assert property (mode_q == clock_gen_pkg::low_power_external_bypass
		|-> out_cfg.factor == clock_gen_pkg::BYPASS_FACTOR && !pll_enable && !fll_enable)
		else $error("Bypass plan wrong.");
	osc_init_a: assert property (!ctrl2_q[clock_gen_pkg::C2_EXT_REF_EN] |-> !status[clock_gen_pkg::ST_OSC_INIT])
		else $error("Oscillator ready shown while disabled.");
endmodule // clock_gen_status

// [src/clock_gen_pkg.sv]
// Package with register map, field layout, reset values, modes and carriers of the clock generator status block.
package clock_gen_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam logic [2:0] OFF_CTRL1 = 3'h0;
	localparam logic [2:0] OFF_CTRL2 = 3'h1;
	localparam logic [2:0] OFF_TRIM = 3'h2;
	localparam logic [2:0] OFF_STATUS = 3'h3;
	localparam logic [2:0] OFF_CTRL3 = 3'h4;
	localparam logic [7:0] CTRL1_RST = 8'h04;
	localparam logic [7:0] CTRL2_RST = 8'h40;
	localparam logic [7:0] TRIM_RST = 8'h80;
	localparam logic [7:0] CTRL3_RST = 8'h01;
	// Control 1: clock mode select, reference divider, reference select.
	localparam int C1_MODE_SEL_HI = 7;
	localparam int C1_MODE_SEL_LO = 6;
	localparam int C1_REF_DIV_HI = 5;
	localparam int C1_REF_DIV_LO = 3;
	localparam int C1_REF_SEL = 2;
	// Control 2: bus divider, range, gain, low power, crystal select, external enable.
	localparam int C2_BUS_DIV_HI = 7;
	localparam int C2_BUS_DIV_LO = 6;
	localparam int C2_LOW_POWER = 3;
	localparam int C2_CRYSTAL_SEL = 2;
	localparam int C2_EXT_REF_EN = 1;
	// Control 3: loss-of-lock irq enable, loop select, loop multiplier.
	localparam int C3_LOL_IRQ_EN = 7;
	localparam int C3_LOOP_SEL = 6;
	localparam int C3_MULT_HI = 3;
	localparam int C3_MULT_LO = 0;
	// Status bits.
	localparam int ST_LOL_FLAG = 7;
	localparam int ST_LOCK = 6;
	localparam int ST_LOOP_STAT = 5;
	localparam int ST_REF_STAT = 4;
	localparam int ST_MODE_STAT_HI = 3;
	localparam int ST_MODE_STAT_LO = 2;
	localparam int ST_OSC_INIT = 1;
	localparam logic [1:0] SRC_LOOP = 2'h0;
	localparam logic [1:0] SRC_INT = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [10:0] FLL_FACTOR = 11'h400;
	localparam logic [10:0] BYPASS_FACTOR = 11'h001;
	typedef enum logic [2:0] {
		fll_engaged_internal_mode, fll_engaged_external_mode, fll_bypassed_internal_mode,
		fll_bypassed_external_mode, pll_engaged_external_mode, pll_bypassed_external_mode,
		low_power_internal_bypass, low_power_external_bypass
	} gen_mode_t;
	// Selections that cross into the generator domain together.
	typedef struct packed {
		logic loop_select;
		logic reference_select;
		logic [1:0] clock_mode_select;
	} sel_t;
	// Frequency plan handed to the analog generator.
	typedef struct packed {
		logic [1:0] src;
		logic [2:0] ref_div_log2;
		logic [1:0] bus_div_log2;
		logic [10:0] factor;
	} out_cfg_t;
endpackage

// [tb/osc_model.sv]
// Behavioural model of the crystal oscillator and analog loops beside the status block.
`timescale 1ns/1ps
module osc_model #(
	parameter int START_CYCLES = 30,
	parameter int LOCK_CYCLES = 4
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic fll_enable,
	input wire logic pll_enable,
	input wire logic lose_lock,
	output logic fll_lock_in,
	output logic pll_lock_in,
	output logic osc_ready_in,
	output logic gen_tick
);
	int start_q = 0;
	int fll_q;
	int pll_q;
	logic [1:0] div_q;
	////////////////////////////////////////
	// The crystal ignores the block reset, so it may be ready before software enables it.
	always @(posedge clk_sys) begin
		start_q <= (start_q < START_CYCLES) ? start_q + 1 : start_q;
	end
	// A loop only locks while enabled; lose_lock pulls it out of tolerance when a test asks.
	always @(posedge clk_sys) begin
		if (!rstn) begin
			fll_q <= 0;
			pll_q <= 0;
			div_q <= 2'h0;
			gen_tick <= 1'b0;
		end else begin
			fll_q <= (fll_enable && !lose_lock) ? ((fll_q < LOCK_CYCLES) ? fll_q + 1 : fll_q) : 0;
			pll_q <= (pll_enable && !lose_lock) ? ((pll_q < LOCK_CYCLES) ? pll_q + 1 : pll_q) : 0;
			div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
			gen_tick <= (div_q == 2'h2);
		end
	end
	assign osc_ready_in = (start_q >= START_CYCLES);
	assign fll_lock_in = fll_enable && (fll_q >= LOCK_CYCLES);
	assign pll_lock_in = pll_enable && (pll_q >= LOCK_CYCLES);
endmodule // osc_model

// [tb/clock_gen_status_test.sv]
// Self-checking testbench of the clock generator status block.
`timescale 1ns/1ps
module clock_gen_status_test;
	localparam logic [2:0] C1 = clock_gen_pkg::OFF_CTRL1;
	localparam logic [2:0] C2 = clock_gen_pkg::OFF_CTRL2;
	localparam logic [2:0] TR = clock_gen_pkg::OFF_TRIM;
	localparam logic [2:0] ST = clock_gen_pkg::OFF_STATUS;
	localparam logic [2:0] C3 = clock_gen_pkg::OFF_CTRL3;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic stop_req = 1'b0;
	logic lose_lock = 1'b0;
	logic [7:0] rdata;
	logic fll_lock_in, pll_lock_in, osc_ready_in, gen_tick, bus_clk, lol_irq, fll_enable, pll_enable;
	logic [7:0] ref_trim;
	clock_gen_pkg::out_cfg_t out_cfg;
	logic [7:0] d;
	logic tick_q = 1'b0;
	logic bus_q = 1'b0;
	int num_errors = 0;
	int n_checks = 0;
	int ticks = 0;
	int toggles = 0;
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	clock_gen_status #(.RELOCK_CYCLES(8), .MULT_STEP(4)) u_clock_gen_status (.clk_sys(clk_sys), .rstn(rstn),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .fll_lock_in(fll_lock_in),
		.pll_lock_in(pll_lock_in), .osc_ready_in(osc_ready_in), .stop_req(stop_req), .gen_tick(gen_tick),
		.bus_clk(bus_clk), .lol_irq(lol_irq), .fll_enable(fll_enable), .pll_enable(pll_enable),
		.ref_trim(ref_trim), .out_cfg(out_cfg));
	osc_model #(.START_CYCLES(30), .LOCK_CYCLES(4)) u_osc_model (.clk_sys(clk_sys), .rstn(rstn),
		.fll_enable(fll_enable), .pll_enable(pll_enable), .lose_lock(lose_lock), .fll_lock_in(fll_lock_in),
		.pll_lock_in(pll_lock_in), .osc_ready_in(osc_ready_in), .gen_tick(gen_tick));
	////////////////////////////////////////
	// Each tick should give exactly one bus clock toggle one cycle later.
	always @(posedge clk_sys) begin
		if (rstn && bus_clk !== bus_q) toggles++;
		if (rstn && tick_q === 1'b1) ticks++;
		bus_q = bus_clk;
		tick_q = gen_tick;
	end
	task automatic stop_test;
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wreg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [2:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		rreg(a);
		chk(18'(d & m), 18'(e));
	endtask
	// Polling is bounded so a lock that never comes ends the run instead of hanging it.
	task automatic wait_st(input int b, input logic v);
		for (int i = 0; i < 200; i++) begin
			rreg(ST);
			if (d[b] === v) return;
		end
		num_errors++;
		$display("[ERR] t=%0t got=%h exp=%h", $time, d[b], v);
		stop_test();
	endtask
	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge clk_sys);
		rstn <= 1'b1;
		rchk(C1, 8'hff, 8'h04);
		chk(out_cfg, {2'h0, 3'h0, 2'h1, 11'h400});
		rchk(C2, 8'hff, 8'h40);
		rchk(TR, 8'hff, 8'h80);
		rchk(C3, 8'hff, 8'h01);
		rchk(3'h7, 8'hff, 8'h00);
		chk({fll_enable, pll_enable}, 2'b10);
		wait_st(6, 1'b1);
		rchk(ST, 8'hff, 8'h50);
		wreg(ST, 8'h7e);
		rchk(ST, 8'hff, 8'h50);
		@(posedge clk_sys) lose_lock <= 1'b1;
		repeat (12) @(posedge clk_sys);
		lose_lock <= 1'b0;
		rchk(ST, 8'hc0, 8'h80);
		chk(lol_irq, 1'b0);
		wait_st(6, 1'b1);
		wreg(ST, 8'h00);
		rchk(ST, 8'h80, 8'h80);
		wreg(ST, 8'h80);
		rchk(ST, 8'h80, 8'h00);
		wreg(C3, 8'h81);
		@(posedge clk_sys) lose_lock <= 1'b1;
		repeat (12) @(posedge clk_sys);
		lose_lock <= 1'b0;
		chk(lol_irq, 1'b1);
		wait_st(6, 1'b1);
		wreg(ST, 8'h80);
		repeat (2) @(posedge clk_sys);
		chk(lol_irq, 1'b0);
		wreg(TR, 8'h90);
		rchk(ST, 8'h40, 8'h00);
		chk(ref_trim, 8'h90);
		wait_st(6, 1'b1);
		@(posedge clk_sys) stop_req <= 1'b1;
		rchk(ST, 8'h40, 8'h00);
		@(posedge clk_sys) stop_req <= 1'b0;
		wait_st(6, 1'b1);
		wreg(C2, 8'h36);
		wait_st(1, 1'b1);
		wreg(C1, 8'h28);
		repeat (4) @(posedge clk_sys);
		rchk(ST, 8'h1c, 8'h00);
		chk(out_cfg, {2'h0, 3'h5, 2'h0, 11'h400});
		wreg(C1, 8'ha8);
		repeat (4) @(posedge clk_sys);
		rchk(ST, 8'h1c, 8'h08);
		chk({out_cfg.src, out_cfg.bus_div_log2, out_cfg.factor}, {2'h2, 2'h0, 11'h001});
		wreg(C1, 8'h90);
		wreg(C3, 8'h43);
		repeat (4) @(posedge clk_sys);
		rchk(ST, 8'h3c, 8'h28);
		chk(pll_enable, 1'b1);
		wreg(C1, 8'h10);
		repeat (4) @(posedge clk_sys);
		rchk(ST, 8'h3c, 8'h2c);
		chk({out_cfg.src, out_cfg.factor}, {2'h3, 11'h00c});
		wait_st(6, 1'b1);
		wreg(C3, 8'h44);
		rchk(ST, 8'h40, 8'h00);
		wait_st(6, 1'b1);
		wreg(C1, 8'h90);
		wreg(C2, 8'h3e);
		repeat (24) @(posedge clk_sys);
		rchk(ST, 8'h40, 8'h00);
		chk({out_cfg.src, out_cfg.factor}, {2'h2, 11'h001});
		wreg(C2, 8'h36);
		wait_st(6, 1'b1);
		chk(18'(toggles), 18'(ticks));
		chk(18'(ticks > 20), 18'h1);
		stop_test();
	end
endmodule // clock_gen_status_test
